// [rtl/ilm_exec_top.sv]
// executor of the indirect and literal move instructions behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "ilm_consts.svh"

// Behaviour
// - indirect port reads memory at pointer address
// - mode field 00/01/10/11 pre/post inc/dec
// - pre modes use pointer plus/minus one
// - offset form adds signed -32..31 literal
// - pointer steps by one, offset leaves it
// - 16-bit pointers wrap at both ends
// - bank load takes 6-bit literal, flags kept
// - latch load takes 7-bit literal, flags kept
// - working load takes 8-bit literal, one cycle
module ilm_exec_top
  import ilm_pkg::*;
#(
  parameter int MEM_AW = 8
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // ahb-lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // core state
  output logic [7:0] O_W,
  output logic [5:0] O_BANK,
  output logic [6:0] O_PCH_LATCH,
  output logic O_ZERO
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (MEM_AW < 1 || MEM_AW > 16) begin : g_bad_aw
    $error("MEM_AW must lie between 1 and 16");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] mem [2**MEM_AW];
  logic [7:0] w_ff, nxt_w;
  logic [5:0] bank_ff, nxt_bank;
  logic [6:0] pch_ff, nxt_pch;
  logic z_ff, nxt_z;
  ilm_addr_t fsr_ff [2];
  ilm_addr_t nxt_fsr [2];
  ilm_addr_t maddr_ff, nxt_maddr;
  logic wr_pend_ff;
  logic [`ILM_OFS_MSB:0] wr_ofs_ff;
  logic [31:0] rdata_ff;
  logic ready_ff;
  logic resp_ff;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic ilm_op_e op_of(input logic [`ILM_IW_W-1:0] w);
    ilm_op_e o;
    o = ILM_OP_NONE;
    case (w[`ILM_OPF_MSB:`ILM_OPF_LSB])
      `ILM_OPC_IND_MODE: o = ILM_OP_IND_MODE;
      `ILM_OPC_IND_OFS: o = ILM_OP_IND_OFS;
      `ILM_OPC_LIT_BANK: o = ILM_OP_LIT_BANK;
      `ILM_OPC_LIT_PCH: o = ILM_OP_LIT_PCH;
      `ILM_OPC_LIT_W: o = ILM_OP_LIT_W;
      default: o = ILM_OP_NONE;
    endcase
    return o;
  endfunction

  function automatic logic is_ind(input ilm_op_e o);
    return (o == ILM_OP_IND_MODE) || (o == ILM_OP_IND_OFS);
  endfunction

  // ----------------------------------------------------------------
  // bus address phase
  // ----------------------------------------------------------------
  logic acc_valid;
  logic sw_wr;
  logic [`ILM_OFS_MSB:0] rd_ofs;

  // hsize is not checked: every access is served as a whole word
  assign acc_valid = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign sw_wr = wr_pend_ff;
  assign rd_ofs = I_HADDR[`ILM_OFS_MSB:0];

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff <= '0;
    end else begin
      wr_pend_ff <= acc_valid && I_HWRITE;
      wr_ofs_ff <= rd_ofs;
    end
  end

  // ----------------------------------------------------------------
  // instruction execute
  // ----------------------------------------------------------------
  logic [`ILM_IW_W-1:0] iw;
  ilm_op_e op;
  logic sel;
  logic [7:0] rd_byte;
  ilm_ptr_if p ();

  assign iw = I_HWDATA[`ILM_IW_W-1:0];
  // an instruction runs in the data phase of its write, one cycle each
  assign op = (sw_wr && wr_ofs_ff == `ILM_OFS_INSTR) ? op_of(iw) : ILM_OP_NONE;
  assign sel = (op == ILM_OP_IND_OFS) ? iw[`ILM_IDX_OFS_BIT] : iw[`ILM_IDX_MODE_BIT];

  always_comb begin
    p.ptr = fsr_ff[sel];
    p.op = op;
    p.pmode = ilm_pmode_e'(iw[`ILM_PMODE_MSB:`ILM_PMODE_LSB]);
    p.ofs = iw[`ILM_KOFS_MSB:0];
  end

  ilm_ptr_unit u_ptr (
    .p(p)
  );

  // no indirect storage
  // upper pointer bits above MEM_AW alias onto the same bytes
  assign rd_byte = mem[p.eff_addr[MEM_AW-1:0]];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_w = w_ff;
    nxt_z = z_ff;
    nxt_bank = bank_ff;
    nxt_pch = pch_ff;
    nxt_maddr = maddr_ff;
    if (sw_wr) begin
      unique case (wr_ofs_ff)
        `ILM_OFS_W: nxt_w = I_HWDATA[7:0];
        `ILM_OFS_STATUS: nxt_z = I_HWDATA[`ILM_ZERO_BIT];
        `ILM_OFS_BANK: nxt_bank = I_HWDATA[5:0];
        `ILM_OFS_PCH: nxt_pch = I_HWDATA[6:0];
        `ILM_OFS_MADDR: nxt_maddr = I_HWDATA[15:0];
        default: nxt_w = w_ff;
      endcase
    end
    unique case (op)
      ILM_OP_IND_MODE, ILM_OP_IND_OFS: begin
        nxt_w = rd_byte;
        nxt_z = (rd_byte == 8'h00);
      end
      ILM_OP_LIT_BANK: nxt_bank = iw[`ILM_KBANK_MSB:0];
      ILM_OP_LIT_PCH: nxt_pch = iw[`ILM_KPCH_MSB:0];
      ILM_OP_LIT_W: nxt_w = iw[`ILM_KW_MSB:0];
      default: nxt_z = nxt_z;
    endcase
  end

  for (genvar i = 0; i < 2; i++) begin : g_fsr
    always_comb begin
      nxt_fsr[i] = fsr_ff[i];
      if (sw_wr && wr_ofs_ff == (i == 0 ? `ILM_OFS_FSR0 : `ILM_OFS_FSR1)) begin
        nxt_fsr[i] = I_HWDATA[15:0];
      end
      if (is_ind(op) && sel == 1'(i)) begin
        nxt_fsr[i] = p.ptr_next;
      end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
        fsr_ff[i] <= `ILM_RST_FSR;
      end else begin
        fsr_ff[i] <= nxt_fsr[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      w_ff <= `ILM_RST_W;
      z_ff <= 1'b0;
      bank_ff <= `ILM_RST_BANK;
      pch_ff <= `ILM_RST_PCH;
      maddr_ff <= `ILM_RST_MADDR;
    end else begin
      w_ff <= nxt_w;
      z_ff <= nxt_z;
      bank_ff <= nxt_bank;
      pch_ff <= nxt_pch;
      maddr_ff <= nxt_maddr;
    end
  end

  // data memory is loaded by software and carries no reset
  always_ff @(posedge I_CORE_CLK) begin
    if (sw_wr && wr_ofs_ff == `ILM_OFS_MDATA) begin
      mem[maddr_ff[MEM_AW-1:0]] <= I_HWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [7:0] mem_rd;

  // next-state values are read so a read right after a write is never stale
  always_comb begin
    mem_rd = mem[nxt_maddr[MEM_AW-1:0]];
    if (sw_wr && wr_ofs_ff == `ILM_OFS_MDATA) begin
      mem_rd = I_HWDATA[7:0];
    end
    rd_mux = 32'h0000_0000;
    unique case (rd_ofs)
      `ILM_OFS_W: rd_mux = {24'h00_0000, nxt_w};
      `ILM_OFS_BANK: rd_mux = {26'h000_0000, nxt_bank};
      `ILM_OFS_PCH: rd_mux = {25'h000_0000, nxt_pch};
      `ILM_OFS_STATUS: rd_mux = {31'h0000_0000, nxt_z};
      `ILM_OFS_FSR0: rd_mux = {16'h0000, nxt_fsr[0]};
      `ILM_OFS_FSR1: rd_mux = {16'h0000, nxt_fsr[1]};
      `ILM_OFS_MADDR: rd_mux = {16'h0000, nxt_maddr};
      `ILM_OFS_MDATA: rd_mux = {24'h00_0000, mem_rd};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b1;
      resp_ff <= 1'b0;
    end else begin
      rdata_ff <= (acc_valid && !I_HWRITE) ? rd_mux : 32'h0000_0000;
      ready_ff <= 1'b1;
      resp_ff <= 1'b0;
    end
  end

  assign O_HRDATA = rdata_ff;
  assign O_HREADYOUT = ready_ff;
  assign O_HRESP = resp_ff;
  assign O_W = w_ff;
  assign O_BANK = bank_ff;
  assign O_PCH_LATCH = pch_ff;
  assign O_ZERO = z_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RSTN);

  ilm_addr_t other_ptr;
  assign other_ptr = fsr_ff[~sel];

  ind_w_load_a: assert property (
    is_ind(op) |=> w_ff == $past(mem[p.eff_addr[MEM_AW-1:0]])
  ) else $error("indirect move did not load addressed byte");

  mode_decode_a: assert property (
    op == ILM_OP_IND_MODE && !iw[1] |-> p.eff_addr != p.ptr
  ) else $error("pre mode used unmodified pointer");

  pre_addr_a: assert property (
    op == ILM_OP_IND_MODE |-> p.eff_addr ==
      (iw[1] ? p.ptr : (iw[0] ? 16'(p.ptr - 16'h0001) : 16'(p.ptr + 16'h0001)))
  ) else $error("wrong effective address in mode form");

  ofs_addr_a: assert property (
    op == ILM_OP_IND_OFS |-> p.eff_addr == 16'(p.ptr + {{10{iw[5]}}, iw[5:0]})
      ##1 fsr_ff[$past(sel)] == $past(p.ptr)
  ) else $error("offset form address or pointer wrong");

  ptr_step_a: assert property (
    op == ILM_OP_IND_MODE |=> fsr_ff[$past(sel)] ==
      ($past(iw[0]) ? 16'($past(p.ptr) - 16'h0001) : 16'($past(p.ptr) + 16'h0001))
  ) else $error("pointer not stepped by one");

  ptr_wrap_a: assert property (
    op == ILM_OP_IND_MODE && p.ptr == 16'hffff && !iw[0] |=> fsr_ff[$past(sel)] == 16'h0000
  ) else $error("pointer did not wrap to zero");

  bank_load_a: assert property (
    op == ILM_OP_LIT_BANK |=> bank_ff == $past(iw[5:0]) && $stable(z_ff)
  ) else $error("bank literal load wrong");

  latch_load_a: assert property (
    op == ILM_OP_LIT_PCH |=> pch_ff == $past(iw[6:0]) && $stable(z_ff)
  ) else $error("latch literal load wrong");

  w_lit_load_a: assert property (
    op == ILM_OP_LIT_W |=> w_ff == $past(iw[7:0]) && $stable(z_ff) && O_W == w_ff
  ) else $error("working literal load wrong");

  zero_flag_a: assert property (
    is_ind(op) |=> z_ff == (w_ff == 8'h00)
  ) else $error("zero flag does not match moved byte");

  other_ptr_a: assert property (
    is_ind(op) && !(sw_wr && wr_ofs_ff != `ILM_OFS_INSTR) |=> fsr_ff[~$past(sel)] ==
      $past(other_ptr)
  ) else $error("unselected pointer changed");

  cov_preinc_wrap: cover property (op == ILM_OP_IND_MODE && !iw[1] && p.ptr == 16'hffff);
  cov_neg_ofs: cover property (op == ILM_OP_IND_OFS && iw[5]);
  cov_zero_move: cover property (is_ind(op) && rd_byte == 8'h00);
  cov_lit_then_read: cover property (op == ILM_OP_LIT_W ##1 acc_valid && !I_HWRITE);
endmodule
`default_nettype wire

// [rtl/ilm_consts.svh]
// offsets, instruction fields, reset values and timing counts of the move executor
`ifndef ILM_CONSTS_SVH
`define ILM_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define ILM_OFS_INSTR 8'h00
`define ILM_OFS_W 8'h04
`define ILM_OFS_BANK 8'h08
`define ILM_OFS_PCH 8'h0c
`define ILM_OFS_STATUS 8'h10
`define ILM_OFS_FSR0 8'h14
`define ILM_OFS_FSR1 8'h18
`define ILM_OFS_MADDR 8'h1c
`define ILM_OFS_MDATA 8'h20
`define ILM_OFS_MSB 7

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define ILM_IW_W 14
`define ILM_OPF_MSB 13
`define ILM_OPF_LSB 11
`define ILM_OPC_NONE 3'h0
`define ILM_OPC_IND_MODE 3'h1
`define ILM_OPC_IND_OFS 3'h2
`define ILM_OPC_LIT_BANK 3'h3
`define ILM_OPC_LIT_PCH 3'h4
`define ILM_OPC_LIT_W 3'h5
`define ILM_IDX_MODE_BIT 2
`define ILM_IDX_OFS_BIT 6
`define ILM_PMODE_MSB 1
`define ILM_PMODE_LSB 0
`define ILM_PMODE_PREINC 2'h0
`define ILM_PMODE_PREDEC 2'h1
`define ILM_PMODE_POSTINC 2'h2
`define ILM_PMODE_POSTDEC 2'h3
`define ILM_KOFS_MSB 5
`define ILM_KBANK_MSB 5
`define ILM_KPCH_MSB 6
`define ILM_KW_MSB 7
`define ILM_ZERO_BIT 0

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define ILM_RST_W 8'h00
`define ILM_RST_BANK 6'h00
`define ILM_RST_PCH 7'h00
`define ILM_RST_FSR 16'h0000
`define ILM_RST_MADDR 16'h0000
`define ILM_PTR_STEP 16'h0001
`define ILM_EXEC_CYCLES 1

`endif

// [rtl/ilm_pkg.sv]
// types shared by the move executor and its pointer unit
`default_nettype none
package ilm_pkg;
`include "ilm_consts.svh"

  typedef enum logic [2:0] {
    ILM_OP_NONE = `ILM_OPC_NONE,
    ILM_OP_IND_MODE = `ILM_OPC_IND_MODE,
    ILM_OP_IND_OFS = `ILM_OPC_IND_OFS,
    ILM_OP_LIT_BANK = `ILM_OPC_LIT_BANK,
    ILM_OP_LIT_PCH = `ILM_OPC_LIT_PCH,
    ILM_OP_LIT_W = `ILM_OPC_LIT_W
  } ilm_op_e;

  typedef enum logic [1:0] {
    ILM_PMODE_PREINC = `ILM_PMODE_PREINC,
    ILM_PMODE_PREDEC = `ILM_PMODE_PREDEC,
    ILM_PMODE_POSTINC = `ILM_PMODE_POSTINC,
    ILM_PMODE_POSTDEC = `ILM_PMODE_POSTDEC
  } ilm_pmode_e;

  typedef logic [15:0] ilm_addr_t;
endpackage
`default_nettype wire

// [rtl/ilm_ptr_if.sv]
// link between the executor and its pointer arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface ilm_ptr_if;
  import ilm_pkg::*;
  ilm_addr_t ptr;
  ilm_op_e op;
  ilm_pmode_e pmode;
  logic [5:0] ofs;
  ilm_addr_t eff_addr;
  ilm_addr_t ptr_next;
  modport exec (output ptr, output op, output pmode, output ofs, input eff_addr, input ptr_next);
  modport unit (input ptr, input op, input pmode, input ofs, output eff_addr, output ptr_next);
endinterface
`default_nettype wire

// [rtl/ilm_ptr_unit.sv]
// pointer unit: effective address and updated pointer of an indirect move
`timescale 1ns/1ps
`default_nettype none
module ilm_ptr_unit
  import ilm_pkg::*;
(
  // pointer request and answer
  ilm_ptr_if.unit p
);
  ilm_addr_t ofs_ext;

  // 16-bit sums wrap on their own, so no bound checks are needed
  assign ofs_ext = {{10{p.ofs[5]}}, p.ofs};

  always_comb begin
    p.eff_addr = p.ptr;
    p.ptr_next = p.ptr;
    unique case (p.op)
      ILM_OP_IND_MODE: begin
        unique case (p.pmode)
          ILM_PMODE_PREINC: begin
            p.eff_addr = 16'(p.ptr + `ILM_PTR_STEP);
            p.ptr_next = 16'(p.ptr + `ILM_PTR_STEP);
          end
          ILM_PMODE_PREDEC: begin
            p.eff_addr = 16'(p.ptr - `ILM_PTR_STEP);
            p.ptr_next = 16'(p.ptr - `ILM_PTR_STEP);
          end
          ILM_PMODE_POSTINC: begin
            p.ptr_next = 16'(p.ptr + `ILM_PTR_STEP);
          end
          ILM_PMODE_POSTDEC: begin
            p.ptr_next = 16'(p.ptr - `ILM_PTR_STEP);
          end
        endcase
      end
      ILM_OP_IND_OFS: begin
        p.eff_addr = 16'(p.ptr + ofs_ext);
      end
      default: begin
        p.eff_addr = p.ptr;
      end
    endcase
  end
endmodule
`default_nettype wire

// [dv/tb_indirect_and_literal_move_exec.sv]
// self-checking bench of the move executor, driven over its ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "ilm_consts.svh"
module tb_indirect_and_literal_move_exec;
  import ilm_pkg::*;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic clk;
  logic rstn;
  logic hsel;
  logic hwrite;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic zero;
  logic rd_dp;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] w;
  logic [5:0] bank;
  logic [6:0] pch;
  int mismatches;
  int n_tests;
  logic [31:0] exp_q[$];
  logic [15:0] rng;
  logic [7:0] m_mem[256];
  logic [7:0] m_w;
  logic [5:0] m_bank;
  logic [6:0] m_pch;
  logic m_z;
  logic n;
  logic [1:0] pmode;
  logic [15:0] p;
  logic [15:0] np;
  logic [15:0] ea;
  logic [5:0] k6;
  logic [7:0] b;

  assign hready = hreadyout;

  ilm_exec_top #(.MEM_AW(8)) u_ilm_exec_top (
    .I_CORE_CLK(clk), .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .O_W(w), .O_BANK(bank),
    .O_PCH_LATCH(pch), .O_ZERO(zero));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic results;
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic judge(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp);
    judge(got, exp);
  endtask

  task automatic cmp_port(input logic [31:0] got, input logic [31:0] exp);
    judge(got, exp);
  endtask

  // hreadyout is registered, so its level at the falling edge is what the next rise samples
  task automatic wait_rdy;
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 100);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      results();
    end else begin
      @(posedge clk);
    end
  endtask

  task automatic bus_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus_xfer(a, 1'b0, 32'h0);
  endtask

  task automatic exec(input logic [13:0] iw);
    bus_xfer(`ILM_OFS_INSTR, 1'b1, {18'h0, iw});
    @(negedge clk);
    cmp_port({24'h0, w}, {24'h0, m_w});
    cmp_port({26'h0, bank}, {26'h0, m_bank});
    cmp_port({25'h0, pch}, {25'h0, m_pch});
    cmp_port({31'h0, zero}, {31'h0, m_z});
    @(posedge clk);
  endtask

  function automatic logic [7:0] fsr_ofs(input logic idx);
    return idx ? `ILM_OFS_FSR1 : `ILM_OFS_FSR0;
  endfunction

  // ----------------------------------------------------------------
  // read data monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    rd_dp <= rstn && hsel && htrans[1] && !hwrite && hready;
  end

  always @(negedge clk) begin
    if (rd_dp) begin
      cmp_bus({31'h0, hresp}, 32'h0);
      if (exp_q.size() == 0) begin
        cmp_bus(hrdata, 32'hdeadbeef);
      end else begin
        cmp_bus(hrdata, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    mismatches = 0;
    n_tests = 0;
    rng = 16'd23925;
    m_w = `ILM_RST_W;
    m_bank = `ILM_RST_BANK;
    m_pch = `ILM_RST_PCH;
    m_z = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`ILM_OFS_FSR0, 32'h0);
    rd(`ILM_OFS_FSR1, 32'h0);
    rd(`ILM_OFS_STATUS, 32'h0);
    // memory image, with zero bytes at 0x00, where a pointer incremented past ffff lands, and at 0x40
    for (int i = 0; i < 256; i++) begin
      rng = lfsr(rng);
      b = (i == 0 || i == 8'h40) ? 8'h00 : (rng[7:0] | 8'h01);
      m_mem[i] = b;
      bus_xfer(`ILM_OFS_MADDR, 1'b1, i);
      bus_xfer(`ILM_OFS_MDATA, 1'b1, {24'h0, b});
    end
    rd(`ILM_OFS_MDATA, {24'h0, m_mem[255]});
    // every mode on both pointers, first at the wrap bounds, then at random
    for (int i = 0; i < 16; i++) begin
      rng = lfsr(rng);
      n = i[0];
      pmode = i[2:1];
      p = (i < 8) ? (pmode[0] ? 16'h0000 : 16'hffff) : rng;
      bus_xfer(fsr_ofs(n), 1'b1, {16'h0, p});
      np = pmode[0] ? p - 16'h0001 : p + 16'h0001;
      ea = pmode[1] ? p : np;
      m_w = m_mem[ea[7:0]];
      m_z = (m_w == 8'h00);
      exec({`ILM_OPC_IND_MODE, 8'h00, n, pmode});
      rd(fsr_ofs(n), {16'h0, np});
    end
    // offset form at both ends of the literal range and into a zero byte
    for (int i = 0; i < 4; i++) begin
      rng = lfsr(rng);
      n = i[0];
      k6 = (i == 0) ? 6'h20 : (i == 1) ? 6'h1f : (i == 2) ? 6'h00 : rng[13:8];
      p = (i == 0) ? 16'h0010 : (i == 2) ? 16'h3340 : rng;
      bus_xfer(fsr_ofs(n), 1'b1, {16'h0, p});
      ea = p + {{10{k6[5]}}, k6};
      m_w = m_mem[ea[7:0]];
      m_z = (m_w == 8'h00);
      exec({`ILM_OPC_IND_OFS, 4'h0, n, k6});
      rd(fsr_ofs(n), {16'h0, p});
    end
    // literal loads keep the zero flag in either state
    for (int i = 0; i < 4; i++) begin
      rng = lfsr(rng);
      m_z = i[0];
      bus_xfer(`ILM_OFS_STATUS, 1'b1, {31'h0, m_z});
      m_bank = rng[5:0];
      exec({`ILM_OPC_LIT_BANK, 4'h0, rng[6:0]});
      m_pch = rng[14:8];
      exec({`ILM_OPC_LIT_PCH, 4'h0, rng[14:8]});
      m_w = rng[15:8];
      exec({`ILM_OPC_LIT_W, 3'h0, rng[15:8]});
      rd(`ILM_OFS_W, {24'h0, m_w});
      rd(`ILM_OFS_BANK, {26'h0, m_bank});
      rd(`ILM_OFS_PCH, {25'h0, m_pch});
      rd(`ILM_OFS_STATUS, {31'h0, m_z});
    end
    // unused opcodes and unmapped places change nothing
    exec({3'h0, rng[10:0]});
    exec({3'h6, rng[10:0]});
    exec({3'h7, rng[10:0]});
    rd(8'h24, 32'h0);
    rd(`ILM_OFS_INSTR, 32'h0);
    repeat (2) @(posedge clk);
    results();
  end
endmodule
`default_nettype wire
